/* File: drive_fault_trip_manager.sv */
// Fault classification, latching, priority display and APB register file
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module drive_fault_trip_manager #(
    parameter longint LINK_LOSS_CYCLES = trip_pkg::LINK_LOSS_CYC,
    parameter longint DRIVE_OL_CYCLES = trip_pkg::OL_HOLD_CYC,
    parameter longint THERMAL_CYCLES = trip_pkg::OL_HOLD_CYC
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire trip_pkg::sense_s SENSE,
    input wire trip_pkg::meas_s MEAS,
    input wire logic EXT_CLOSED_PIN,
    input wire logic EXT_OPEN_PIN,
    input wire logic LINK_BEAT,
    input wire logic BRAKE_ACTIVE,
    input wire logic FAULT_RESET,
    output logic DRIVE_INHIBIT,
    output logic WARNING,
    output logic [trip_pkg::CODE_W-1:0] DISPLAY_CODE
);

    localparam int N = trip_pkg::NUM_TRIPS;
    localparam int CW = trip_pkg::CURR_W;
    localparam int AW = 56;

    if (LINK_LOSS_CYCLES < 1 || LINK_LOSS_CYCLES > 64'hFFFF_FFFF) begin : g_bad_link
        $error("LINK_LOSS_CYCLES out of range");
    end
    if (DRIVE_OL_CYCLES < 1 || DRIVE_OL_CYCLES > 64'hF_FFFF_FFFF) begin : g_bad_ol
        $error("DRIVE_OL_CYCLES out of range");
    end
    if (THERMAL_CYCLES < 1 || THERMAL_CYCLES > 64'hF_FFFF_FFFF) begin : g_bad_th
        $error("THERMAL_CYCLES out of range");
    end
    // Log index is three bits wide
    if (trip_pkg::WLOG_DEPTH < 1 || trip_pkg::WLOG_DEPTH > 8) begin : g_bad_log
        $error("WLOG_DEPTH out of range");
    end

    // Inverse-time heat: excess over rating accumulates, deficit cools
    function automatic logic [AW-1:0] heat_next(input logic [AW-1:0] acc,
                                                input logic [CW-1:0] cur,
                                                input logic [CW-1:0] rated);
        logic [AW-1:0] diff;
        diff = '0;
        if (cur > rated) begin
            diff = AW'(cur - rated);
            heat_next = acc + diff;
        end else begin
            diff = AW'(rated - cur);
            heat_next = (acc > diff) ? acc - diff : '0;
        end
    endfunction

    // Budget reached at 150% load after the hold time
    function automatic logic [AW-1:0] heat_limit(input logic [CW-1:0] rated,
                                                 input longint cycles);
        logic [AW-1:0] excess;
        excess = AW'(rated) * AW'(trip_pkg::OL_RATE_PCT - 100) / AW'(100);
        heat_limit = excess * AW'(cycles);
    endfunction

    // First set bit wins
    function automatic logic [trip_pkg::CODE_W-1:0] first_code(input logic [N-1:0] v);
        logic [trip_pkg::CODE_W-1:0] c;
        c = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                c = trip_pkg::CODE_W'(i + 1);
            end
        end
        first_code = c;
    endfunction

    // Register file
    logic [31:0] config_reg;
    logic [CW-1:0] ol_level;
    logic [CW-1:0] drive_rated;
    logic [CW-1:0] motor_rated;
    logic [CW-1:0] brake_release_current;
    logic [CW-1:0] gf_level;
    logic [N-1:0] warn_mask;
    logic [N-1:0] trip_state;
    logic [trip_pkg::CODE_W-1:0] history;
    logic [trip_pkg::CODE_W-1:0] warning_log_entries [trip_pkg::WLOG_DEPTH];
    logic [N-1:0] warn_prev;
    logic [31:0] link_count;
    logic [AW-1:0] drive_heat;
    logic [AW-1:0] motor_heat;

    wire setup_phase = PSEL & ~PENABLE;
    wire wr_access = PSEL & PENABLE & PWRITE;
    wire [7:0] word_addr = {PADDR[7:2], 2'b00};
    wire in_log = (word_addr >= trip_pkg::A_WLOG0) &&
        (word_addr < trip_pkg::A_WLOG0 + 8'(4 * trip_pkg::WLOG_DEPTH));
    wire [7:0] log_off = word_addr - trip_pkg::A_WLOG0;
    wire [2:0] log_idx = log_off[4:2];
    wire addr_rw = word_addr <= trip_pkg::A_RESET_CMD;
    wire addr_ro = (word_addr >= trip_pkg::A_TRIP_STATE && word_addr <= trip_pkg::A_HISTORY)
        || in_log;
    wire mapped = addr_rw | addr_ro;
    wire sw_reset = wr_access && word_addr == trip_pkg::A_RESET_CMD && PWDATA[0];
    wire latch_clear = sw_reset | FAULT_RESET;

    // Config fields
    wire [trip_pkg::SEL_W-1:0] overload_trip_select = config_reg[trip_pkg::F_OL_SEL +: 4];
    wire [trip_pkg::SEL_W-1:0] thermal_trip_select = config_reg[trip_pkg::F_TH_SEL +: 4];
    wire [trip_pkg::SEL_W-1:0] phase_loss_check_select = config_reg[trip_pkg::F_PH_SEL +: 4];
    wire source_wiring = config_reg[trip_pkg::F_PNP];
    wire [4:0] relay_output_one_function = config_reg[trip_pkg::F_RELAY1 +: 5];
    wire [4:0] relay_output_two_function = config_reg[trip_pkg::F_RELAY2 +: 5];

    // Trip conditions
    // Limit is the rated current scaled by the overcurrent factor
    wire [CW+7:0] oc_limit = (CW+8)'((CW+8)'(drive_rated)
        * (CW+8)'(trip_pkg::OC_FACTOR_PCT) / (CW+8)'(100));
    wire ext_closed = source_wiring ? EXT_CLOSED_PIN : ~EXT_CLOSED_PIN;
    wire ext_open_closed = source_wiring ? EXT_OPEN_PIN : ~EXT_OPEN_PIN;
    wire brake_assigned = relay_output_one_function == trip_pkg::FUNC_BRAKE ||
        relay_output_two_function == trip_pkg::FUNC_BRAKE;
    wire [AW-1:0] next_drive_heat = heat_next(drive_heat, MEAS.out_current, drive_rated);
    wire [AW-1:0] next_motor_heat = heat_next(motor_heat, MEAS.out_current, motor_rated);
    wire [31:0] link_limit = 32'(LINK_LOSS_CYCLES);
    wire link_lost = link_count >= link_limit;

    logic [N-1:0] cond;
    always_comb begin
        cond = '0;
        cond[trip_pkg::T_PRECHARGE] = SENSE.precharge_fail;
        cond[trip_pkg::T_OVERCURRENT] = (CW+8)'(MEAS.out_current) > oc_limit;
        cond[trip_pkg::T_GROUND] = MEAS.ground_current > gf_level;
        cond[trip_pkg::T_OVERVOLT] = SENSE.over_voltage;
        cond[trip_pkg::T_DRIVE_OL] =
            drive_heat >= heat_limit(drive_rated, DRIVE_OL_CYCLES);
        cond[trip_pkg::T_HEATSINK] = SENSE.heatsink_hot;
        cond[trip_pkg::T_THERMAL] = thermal_trip_select != '0 &&
            motor_heat >= heat_limit(motor_rated, THERMAL_CYCLES);
        cond[trip_pkg::T_MOTOR_OL] = overload_trip_select != '0 &&
            MEAS.load_level > ol_level;
        cond[trip_pkg::T_PHASE] = phase_loss_check_select[trip_pkg::PH_CHECK_BIT] &&
            (|SENSE.phase_open);
        cond[trip_pkg::T_SENSOR] = SENSE.sensor_bad;
        cond[trip_pkg::T_COOLING] = SENSE.fan_fault;
        cond[trip_pkg::T_EXT_CLOSED] = ext_closed;
        cond[trip_pkg::T_EXT_OPEN] = ~ext_open_closed;
        cond[trip_pkg::T_LINK] = link_lost;
        cond[trip_pkg::T_BRAKE] = brake_assigned && BRAKE_ACTIVE &&
            MEAS.out_current < brake_release_current;
        cond[trip_pkg::T_UNDERVOLT] = SENSE.under_voltage;
    end

    // Per-type holding; a new condition wins over a clear
    wire [N-1:0] held_level = cond & trip_pkg::LEVEL_MASK;
    wire [N-1:0] held_latch = (cond | (trip_state & {N{~latch_clear}}))
        & trip_pkg::LATCH_MASK;
    wire [N-1:0] held_fatal = (cond | trip_state) & trip_pkg::FATAL_MASK;
    wire [N-1:0] next_trip_state = held_level | held_latch | held_fatal;

    wire [N-1:0] halting = next_trip_state & ~warn_mask;
    wire [N-1:0] warns = next_trip_state & warn_mask;
    wire [N-1:0] new_warns = warns & ~warn_prev;
    wire [N-1:0] new_history = next_trip_state & ~trip_state & ~trip_pkg::LEVEL_MASK;
    wire [trip_pkg::CODE_W-1:0] next_display = first_code(next_trip_state);

    logic [31:0] read_mux;
    always_comb begin
        read_mux = '0;
        case (word_addr)
            trip_pkg::A_CONFIG: begin
                read_mux = config_reg;
            end
            trip_pkg::A_OL_LEVEL: begin
                read_mux = 32'(ol_level);
            end
            trip_pkg::A_DRIVE_RATED: begin
                read_mux = 32'(drive_rated);
            end
            trip_pkg::A_MOTOR_RATED: begin
                read_mux = 32'(motor_rated);
            end
            trip_pkg::A_BRAKE_CURR: begin
                read_mux = 32'(brake_release_current);
            end
            trip_pkg::A_GF_LEVEL: begin
                read_mux = 32'(gf_level);
            end
            trip_pkg::A_WARN_MASK: begin
                read_mux = 32'(warn_mask);
            end
            trip_pkg::A_TRIP_STATE: begin
                read_mux = 32'(trip_state);
            end
            trip_pkg::A_DISPLAY: begin
                read_mux = {22'h0, WARNING, DRIVE_INHIBIT, 3'h0, DISPLAY_CODE};
            end
            trip_pkg::A_HISTORY: begin
                read_mux = 32'(history);
            end
            default: begin
                read_mux = in_log ? 32'(warning_log_entries[log_idx]) : 32'h0;
            end
        endcase
    end

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~(PWRITE ? addr_rw : mapped);

    // Read data captured in the setup cycle so it is stable in access
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0;
        end else if (setup_phase && !PWRITE) begin
            PRDATA <= read_mux;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            config_reg <= trip_pkg::CONFIG_RST;
            ol_level <= trip_pkg::CURR_RST;
            drive_rated <= trip_pkg::CURR_RST;
            motor_rated <= trip_pkg::CURR_RST;
            brake_release_current <= '0;
            gf_level <= trip_pkg::CURR_RST;
            warn_mask <= '0;
        end else if (wr_access) begin
            case (word_addr)
                trip_pkg::A_CONFIG: begin
                    config_reg <= PWDATA;
                end
                trip_pkg::A_OL_LEVEL: begin
                    ol_level <= PWDATA[CW-1:0];
                end
                trip_pkg::A_DRIVE_RATED: begin
                    drive_rated <= PWDATA[CW-1:0];
                end
                trip_pkg::A_MOTOR_RATED: begin
                    motor_rated <= PWDATA[CW-1:0];
                end
                trip_pkg::A_BRAKE_CURR: begin
                    brake_release_current <= PWDATA[CW-1:0];
                end
                trip_pkg::A_GF_LEVEL: begin
                    gf_level <= PWDATA[CW-1:0];
                end
                trip_pkg::A_WARN_MASK: begin
                    warn_mask <= PWDATA[N-1:0];
                end
                default: ;
            endcase
        end
    end

    // Link watchdog and heat models
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            link_count <= '0;
            drive_heat <= '0;
            motor_heat <= '0;
        end else begin
            // Counter stops at the limit so the trip cannot wrap away
            if (LINK_BEAT) begin
                link_count <= 32'h0;
            end else if (!link_lost) begin
                link_count <= link_count + 32'h1;
            end
            drive_heat <= next_drive_heat;
            motor_heat <= next_motor_heat;
        end
    end

    // Trip state, outputs and logs; power cycle is the only fatal clear
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            trip_state <= '0;
            warn_prev <= '0;
            history <= '0;
            DRIVE_INHIBIT <= 1'b0;
            WARNING <= 1'b0;
            DISPLAY_CODE <= '0;
            for (int i = 0; i < trip_pkg::WLOG_DEPTH; i++) begin
                warning_log_entries[i] <= '0;
            end
        end else begin
            trip_state <= next_trip_state;
            warn_prev <= warns;
            DRIVE_INHIBIT <= |halting;
            WARNING <= |warns;
            DISPLAY_CODE <= next_display;
            if (|new_history) begin
                history <= first_code(new_history);
            end
            if (|new_warns) begin
                warning_log_entries[0] <= first_code(new_warns);
                for (int i = 1; i < trip_pkg::WLOG_DEPTH; i++) begin
                    warning_log_entries[i] <= warning_log_entries[i-1];
                end
            end
        end
    end

endmodule

/* File: drive_fault_trip_manager_bench.sv */
// Self-checking bench: APB tasks and fault scenarios
`timescale 1ns/1ps
module drive_fault_trip_manager_bench;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, last_err;
    logic fault_reset, close_cmd, open_cmd, link_drop, brake_cmd;
    logic ext_closed, ext_open, link_beat, brake_active, drive_inhibit, warning;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] display_code;
    trip_pkg::sense_s s_cmd, sense;
    trip_pkg::meas_s m_cmd, meas;
    int bad_count, compares;
    localparam logic [8:0] LT_S [4] = '{9'h100, 9'h020, 9'h010, 9'h008};
    localparam int LT_I [4] = '{3, 5, 9, 10};
    localparam logic [7:0] TS = trip_pkg::A_TRIP_STATE;

    drive_fault_trip_manager #(.LINK_LOSS_CYCLES(20), .DRIVE_OL_CYCLES(10),
        .THERMAL_CYCLES(10)) uut (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SENSE(sense), .MEAS(meas),
        .EXT_CLOSED_PIN(ext_closed), .EXT_OPEN_PIN(ext_open), .LINK_BEAT(link_beat),
        .BRAKE_ACTIVE(brake_active), .FAULT_RESET(fault_reset),
        .DRIVE_INHIBIT(drive_inhibit), .WARNING(warning), .DISPLAY_CODE(display_code));
    power_stage_model far (
        .clk(core_clk), .rst(sys_rst), .sense_cmd(s_cmd), .meas_cmd(m_cmd),
        .close_cmd(close_cmd), .open_cmd(open_cmd), .link_drop(link_drop),
        .brake_cmd(brake_cmd), .sense(sense), .meas(meas), .ext_closed(ext_closed),
        .ext_open(ext_open), .link_beat(link_beat), .brake_active(brake_active));

    task automatic final_report();
        $display("mismatches %0d, compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            final_report();
        end
        rd = prdata;
        last_err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Remove every condition, let heat models cool, then pulse reset input
    task automatic clear(input logic [31:0] keep);
        s_cmd <= '0;
        m_cmd <= '0;
        {close_cmd, open_cmd, link_drop, brake_cmd} <= 4'h0;
        cyc(8);
        fault_reset <= 1'b1;
        cyc(1);
        fault_reset <= 1'b0;
        rchk(TS, keep);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, fault_reset, paddr, pwdata} = '0;
        {close_cmd, open_cmd, link_drop, brake_cmd} = 4'h0;
        s_cmd = '0;
        m_cmd = '0;
        bad_count = 0;
        compares = 0;
        cyc(12);
        sys_rst <= 1'b0;
        rchk(trip_pkg::A_CONFIG, 32'h0);
        rchk(trip_pkg::A_OL_LEVEL, 32'h0000FFFF);
        rchk(trip_pkg::A_BRAKE_CURR, 32'h0);
        rchk(8'h40, 32'h0);
        check(last_err, 1'b1);
        xfer(1'b1, TS, 32'h0000FFFF);
        check(last_err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            s_cmd <= LT_S[i];
            cyc(2);
            s_cmd <= '0;
            rchk(trip_pkg::A_DISPLAY, 32'h100 | (LT_I[i] + 1));
            cyc(3);
            rchk(TS, 32'h1 << LT_I[i]);
            check(drive_inhibit, 1'b1);
            clear(32'h0);
        end
        s_cmd <= 9'h028;
        cyc(2);
        rchk(trip_pkg::A_DISPLAY, 32'h106);
        clear(32'h0);
        s_cmd <= 9'h080;
        cyc(2);
        rchk(TS, 32'h8000);
        s_cmd <= '0;
        cyc(2);
        rchk(TS, 32'h0);
        xfer(1'b0, trip_pkg::A_HISTORY, 32'h0);
        check(rd[4:0] === 5'h10, 1'b0);
        xfer(1'b1, trip_pkg::A_DRIVE_RATED, 32'h64);
        xfer(1'b1, trip_pkg::A_MOTOR_RATED, 32'h64);
        xfer(1'b1, trip_pkg::A_OL_LEVEL, 32'hA);
        for (int k = 0; k < 2; k++) begin
            xfer(1'b1, trip_pkg::A_CONFIG, k ? 32'h211 : 32'h100);
            s_cmd <= 9'h001;
            m_cmd <= {16'h0096, 16'h0000, 16'h000B};
            cyc(2);
            rchk(TS, k ? 32'h180 : 32'h0);
            cyc(12);
            rchk(TS, k ? 32'h1D0 : 32'h10);
            clear(32'h0);
        end
        xfer(1'b1, trip_pkg::A_GF_LEVEL, 32'h32);
        m_cmd <= {16'h00C8, 16'h0032, 16'h0000};
        xfer(1'b0, TS, 32'h0);
        check(rd[2:1], 2'b00);
        m_cmd <= {16'h00C9, 16'h0033, 16'h0000};
        cyc(2);
        xfer(1'b0, TS, 32'h0);
        check(rd[2:1], 2'b11);
        clear(32'h0);
        xfer(1'b1, trip_pkg::A_CONFIG, 32'h1300_0000);
        xfer(1'b1, trip_pkg::A_BRAKE_CURR, 32'h32);
        brake_cmd <= 1'b1;
        m_cmd <= {16'h0032, 32'h0};
        cyc(2);
        rchk(TS, 32'h0);
        m_cmd <= {16'h0031, 32'h0};
        cyc(2);
        rchk(TS, 32'h4000);
        clear(32'h0);
        {close_cmd, open_cmd} <= 2'b11;
        cyc(2);
        rchk(TS, 32'h1800);
        clear(32'h0);
        link_drop <= 1'b1;
        cyc(8);
        rchk(TS, 32'h0);
        cyc(20);
        rchk(TS, 32'h2000);
        clear(32'h0);
        xfer(1'b1, trip_pkg::A_WARN_MASK, 32'h20);
        s_cmd <= 9'h020;
        cyc(2);
        check({warning, drive_inhibit}, 2'b10);
        s_cmd <= '0;
        rchk(trip_pkg::A_WLOG0, 32'h6);
        xfer(1'b1, trip_pkg::A_RESET_CMD, 32'h1);
        rchk(TS, 32'h0);
        s_cmd <= 9'h040;
        cyc(2);
        clear(32'h1);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        rchk(TS, 32'h0);
        final_report();
    end
endmodule

/* File: drive_fault_trip_manager_monitor.sv */
// Port-level checker for the trip manager
`timescale 1ns/1ps
module trip_monitor #(
    parameter longint LINK_LOSS_CYCLES = 20
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire trip_pkg::sense_s SENSE,
    input wire logic LINK_BEAT,
    input wire logic FAULT_RESET,
    input wire logic DRIVE_INHIBIT,
    input wire logic WARNING,
    input wire logic [trip_pkg::CODE_W-1:0] DISPLAY_CODE
);
    logic [31:0] silent;
    wire wr_acc = PSEL && PENABLE && PWRITE;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || LINK_BEAT) silent <= 32'h0;
        else if (~&silent) silent <= silent + 32'h1;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    AST_FATAL_SET: assert property (SENSE.precharge_fail |=> DISPLAY_CODE == 5'h01)
        else $error("precharge fault not shown");
    AST_FATAL_HOLD: assert property (DISPLAY_CODE == 5'h01 |=> DISPLAY_CODE == 5'h01)
        else $error("fatal trip dropped before power cycle");
    AST_LEVEL_SET: assert property (SENSE.under_voltage |=> DISPLAY_CODE != 5'h00)
        else $error("undervoltage not shown");
    AST_LEVEL_CLEAR: assert property (!SENSE.under_voltage |=> DISPLAY_CODE != 5'h10)
        else $error("undervoltage held after condition gone");
    AST_OVERVOLT: assert property (SENSE.over_voltage |=> DISPLAY_CODE inside {[5'h01:5'h04]})
        else $error("overvoltage display wrong");
    AST_HEATSINK: assert property (SENSE.heatsink_hot |=> DISPLAY_CODE inside {[5'h01:5'h06]})
        else $error("heatsink display wrong");
    AST_SENSOR: assert property (SENSE.sensor_bad |=> DISPLAY_CODE inside {[5'h01:5'h0A]})
        else $error("sensor fault display wrong");
    AST_FAN: assert property (SENSE.fan_fault |=> DISPLAY_CODE inside {[5'h01:5'h0B]})
        else $error("fan fault display wrong");
    AST_LATCH_HOLD: assert property ((DISPLAY_CODE inside {[5'h02:5'h0F]}) && !FAULT_RESET
        && !wr_acc |=> DISPLAY_CODE != 5'h00) else $error("latched trip lost without reset");
    AST_INHIBIT: assert property (DISPLAY_CODE != 5'h00 && !WARNING |-> DRIVE_INHIBIT)
        else $error("trip active without inhibit");
    AST_IDLE: assert property (DISPLAY_CODE == 5'h00 |-> !DRIVE_INHIBIT && !WARNING)
        else $error("inhibit or warning with no trip");
    AST_LINK: assert property (longint'(silent) > LINK_LOSS_CYCLES + 2 |-> DISPLAY_CODE != 5'h00)
        else $error("link loss not tripped");
endmodule

bind drive_fault_trip_manager trip_monitor #(.LINK_LOSS_CYCLES(LINK_LOSS_CYCLES)) mon (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .SENSE(SENSE), .LINK_BEAT(LINK_BEAT), .FAULT_RESET(FAULT_RESET),
    .DRIVE_INHIBIT(DRIVE_INHIBIT), .WARNING(WARNING), .DISPLAY_CODE(DISPLAY_CODE));

/* File: power_stage_model.sv */
// Far-side model: power stage sensors, terminal inputs and link heartbeat
`timescale 1ns/1ps
module power_stage_model (
    input wire logic clk,
    input wire logic rst,
    input wire trip_pkg::sense_s sense_cmd,
    input wire trip_pkg::meas_s meas_cmd,
    input wire logic close_cmd,
    input wire logic open_cmd,
    input wire logic link_drop,
    input wire logic brake_cmd,
    output trip_pkg::sense_s sense,
    output trip_pkg::meas_s meas,
    output logic ext_closed,
    output logic ext_open,
    output logic link_beat,
    output logic brake_active
);
    logic [1:0] beat_div;
    assign sense = sense_cmd;
    assign meas = meas_cmd;
    // Sink wiring: closed contact pulls low
    assign ext_closed = !close_cmd;
    // Loop stays low until broken
    assign ext_open = open_cmd;
    assign brake_active = brake_cmd;
    always_ff @(posedge clk) begin
        if (rst) beat_div <= 2'h0;
        else beat_div <= beat_div + 2'h1;
    end
    // Heartbeat every fourth cycle unless cut
    assign link_beat = !link_drop && beat_div == 2'h3;
endmodule

/* File: trip_pkg.sv */
// Package with trip indices, register map, field positions and timing constants
package trip_pkg;

    localparam int NUM_TRIPS = 16;

    // Trip index doubles as priority: lower index wins the display
    localparam int T_PRECHARGE = 0;
    localparam int T_OVERCURRENT = 1;
    localparam int T_GROUND = 2;
    localparam int T_OVERVOLT = 3;
    localparam int T_DRIVE_OL = 4;
    localparam int T_HEATSINK = 5;
    localparam int T_THERMAL = 6;
    localparam int T_MOTOR_OL = 7;
    localparam int T_PHASE = 8;
    localparam int T_SENSOR = 9;
    localparam int T_COOLING = 10;
    localparam int T_EXT_CLOSED = 11;
    localparam int T_EXT_OPEN = 12;
    localparam int T_LINK = 13;
    localparam int T_BRAKE = 14;
    localparam int T_UNDERVOLT = 15;

    localparam logic [15:0] FATAL_MASK = 16'h0001;
    localparam logic [15:0] LEVEL_MASK = 16'h8000;
    localparam logic [15:0] LATCH_MASK = 16'h7FFE;

    // APB register byte offsets
    localparam logic [7:0] A_CONFIG = 8'h00;
    localparam logic [7:0] A_OL_LEVEL = 8'h04;
    localparam logic [7:0] A_DRIVE_RATED = 8'h08;
    localparam logic [7:0] A_MOTOR_RATED = 8'h0C;
    localparam logic [7:0] A_BRAKE_CURR = 8'h10;
    localparam logic [7:0] A_GF_LEVEL = 8'h14;
    localparam logic [7:0] A_WARN_MASK = 8'h18;
    localparam logic [7:0] A_RESET_CMD = 8'h1C;
    localparam logic [7:0] A_TRIP_STATE = 8'h20;
    localparam logic [7:0] A_DISPLAY = 8'h24;
    localparam logic [7:0] A_HISTORY = 8'h28;
    localparam logic [7:0] A_WLOG0 = 8'h2C;
    localparam int WLOG_DEPTH = 5;

    // CONFIG fields
    localparam int F_OL_SEL = 0;
    localparam int F_TH_SEL = 4;
    localparam int F_PH_SEL = 8;
    localparam int F_PNP = 12;
    localparam int F_RELAY1 = 16;
    localparam int F_RELAY2 = 24;
    localparam int SEL_W = 4;
    localparam int FUNC_W = 5;
    localparam logic [4:0] FUNC_BRAKE = 5'h13;
    localparam int PH_CHECK_BIT = 1;

    // DISPLAY fields
    localparam int F_INHIBIT = 8;
    localparam int F_WARNING = 9;

    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [15:0] CURR_RST = 16'hFFFF;

    localparam int CURR_W = 16;
    localparam int CODE_W = 5;

    // Timing
    localparam longint CLK_HZ = 50_000_000;
    localparam longint LINK_LOSS_MS = 500;
    localparam longint LINK_LOSS_CYC = LINK_LOSS_MS * CLK_HZ / 1000;
    localparam longint OL_HOLD_S = 60;
    localparam longint OL_HOLD_CYC = OL_HOLD_S * CLK_HZ;
    localparam int OC_FACTOR_PCT = 200;
    localparam int OL_RATE_PCT = 150;

    typedef struct packed {
        logic over_voltage;
        logic under_voltage;
        logic precharge_fail;
        logic heatsink_hot;
        logic sensor_bad;
        logic fan_fault;
        logic [2:0] phase_open;
    } sense_s;

    typedef struct packed {
        logic [CURR_W-1:0] out_current;
        logic [CURR_W-1:0] ground_current;
        logic [CURR_W-1:0] load_level;
    } meas_s;

endpackage
